// [sim/avsl_host.sv]
// Host side of the reply stream: collects reply bytes, may stall
`timescale 1ns/10ps
`default_nettype none
module avsl_host (
  input  wire logic       i_mclk,     // Clock
  input  wire logic       i_slow,     // Stall every other cycle
  input  wire logic       i_tx_valid, // Byte present
  input  wire logic [7:0] i_tx_data,  // Byte
  output logic            o_tx_ready  // Byte taken
);
  logic [7:0] rx[$];
  initial o_tx_ready = 1'b0;
  always @(posedge i_mclk) begin
    if (i_tx_valid && o_tx_ready) begin
      rx.push_back(i_tx_data);
    end
  end
  always @(negedge i_mclk) begin
    o_tx_ready <= i_slow ? !o_tx_ready : 1'b1;
  end
endmodule
`default_nettype wire

// [sim/avsl_properties.sv]
// Port checks of the command block, bound to its top
`timescale 1ns/10ps
`default_nettype none
module avsl_properties (
  input wire logic               i_mclk,          // Clock
  input wire logic               i_sys_rst,       // Reset
  input wire logic               i_cmd_valid,     // Command
  input wire logic               o_cmd_ready,     // Taken
  input wire avsl_pkg::avsl_op_t i_cmd_op,        // Code
  input wire logic               i_cmd_all,       // All ids
  input wire logic [3:0]         i_cmd_id,        // Id
  input wire logic signed [31:0] i_cmd_value,     // Value
  input wire logic               o_tx_valid,      // Reply
  input wire logic [7:0]         o_tx_data,       // Byte
  input wire logic               i_tx_ready,      // Sink
  input wire logic [7:0]         o_err_code,      // Error
  input wire logic [255:0]       i_axis_pos,      // Positions
  input wire logic [7:0]         i_axis_moving,   // Moving
  input wire logic [7:0]         i_servo_on,      // Servo
  input wire logic [7:0]         i_soft_limit_en, // Enable
  input wire logic [255:0]       o_low_limit,     // Limits
  input wire logic [7:0]         o_low_limit_hit, // Hit
  input wire logic [1:0]         i_ain_fitted     // Fitted
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  wire logic               tk = i_cmd_valid && o_cmd_ready;
  wire logic signed [31:0] p0 = i_axis_pos[31:0];
  wire logic signed [31:0] l0 = o_low_limit[31:0];
  wire logic               x0 = tk && i_cmd_id == 4'h0 && i_cmd_op == avsl_pkg::OP_SET_LOW_SOFT_LIMIT;
  wire logic               na = tk && i_cmd_op == avsl_pkg::OP_SET_AVERAGE_COUNT;
  wire logic               ot = tk && i_cmd_op == avsl_pkg::OP_GET_ON_TARGET_STATE;
  sequence s_lim_ok;
    x0 && !i_axis_moving[0] && i_cmd_value < p0 && i_cmd_value < 0;
  endsequence
  sequence s_lim_bad;
    x0 && !i_axis_moving[0] && i_cmd_value >= p0;
  endsequence
  sequence s_x_sent;
    o_tx_valid && o_tx_data == 8'h58;
  endsequence
  a_reply_holds: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("reply byte changed before taken");
  a_busy_replying: assert property (o_tx_valid |-> !o_cmd_ready)
    else $error("command taken during reply");
  a_count_high: assert property (na && i_cmd_id == 4'h1 && i_ain_fitted[0]
    && i_cmd_value > avsl_pkg::NAV_MAX |=> o_err_code == avsl_pkg::ERR_VALUE) else $error("big count kept");
  a_count_chan: assert property (na && i_cmd_id == 4'h0 |=> o_err_code == avsl_pkg::ERR_BAD_ID)
    else $error("bad channel kept");
  a_set_silent: assert property (x0 |=> !o_tx_valid)
    else $error("set produced a reply");
  a_limit_kept: assert property (s_lim_bad |=> o_err_code == avsl_pkg::ERR_SOFTLIM && $stable(l0))
    else $error("limit at or above position taken");
  a_limit_moving: assert property (x0 && i_axis_moving[0]
    |=> o_err_code == avsl_pkg::ERR_MOVING && $stable(l0)) else $error("limit changed while moving");
  a_limit_taken: assert property (s_lim_ok |=> l0 == $past(i_cmd_value))
    else $error("legal limit not stored");
  a_hit_raised: assert property (i_soft_limit_en[0] && i_servo_on[0] && p0 < l0 |=> o_low_limit_hit[0])
    else $error("limit not enforced");
  a_hit_off: assert property (!i_soft_limit_en[0] |=> !o_low_limit_hit[0])
    else $error("limit enforced while disabled");
  a_ont_first: assert property (ot && (i_cmd_all || i_cmd_id == 4'h0) |-> ##[1:4] s_x_sent)
    else $error("on-target reply not led by first axis");
endmodule
bind avsl_top avsl_properties u_props (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_cmd_valid(i_cmd_valid),
  .o_cmd_ready(o_cmd_ready), .i_cmd_op(i_cmd_op), .i_cmd_all(i_cmd_all), .i_cmd_id(i_cmd_id),
  .i_cmd_value(i_cmd_value), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready),
  .o_err_code(o_err_code), .i_axis_pos(i_axis_pos), .i_axis_moving(i_axis_moving), .i_servo_on(i_servo_on),
  .i_soft_limit_en(i_soft_limit_en), .o_low_limit(o_low_limit), .o_low_limit_hit(o_low_limit_hit),
  .i_ain_fitted(i_ain_fitted));
`default_nettype wire

// [sim/avsl_top_tb.sv]
// Self-checking bench for the command block
`timescale 1ns/10ps
`default_nettype none
module avsl_top_tb;
  avsl_pkg::avsl_op_t op_sa = avsl_pkg::OP_SET_AVERAGE_COUNT;
  avsl_pkg::avsl_op_t op_ga = avsl_pkg::OP_GET_AVERAGE_COUNT;
  avsl_pkg::avsl_op_t op_sl = avsl_pkg::OP_SET_LOW_SOFT_LIMIT;
  avsl_pkg::avsl_op_t op_gl = avsl_pkg::OP_GET_LOW_SOFT_LIMIT;
  avsl_pkg::avsl_op_t op_ot = avsl_pkg::OP_GET_ON_TARGET_STATE;
  avsl_pkg::avsl_op_t op = avsl_pkg::OP_GET_ON_TARGET_STATE;
  logic clk = 1'b0, rst = 1'b1, cv = 1'b0, call = 1'b0, er = 1'b0, sv = 1'b0, slow = 1'b0, sc = 1'b0;
  logic [3:0] id = 4'h0;
  logic signed [31:0] val = 32'h0;
  logic [7:0] mov = 8'h00, ont = 8'h00, srv = 8'hff, sle = 8'h00, ert, hit, txd;
  logic [1:0] fit = 2'b11, mv;
  logic [15:0] sd = 16'h0000;
  logic [7:0][31:0] pos = '0, tmin = {8{32'hffff_ffea}}, lim;
  logic [31:0] mean;
  logic rdy, txv, txr;
  int num_errors = 0;
  int samples_checked = 0;
  always #5 clk = !clk;
  avsl_top u_dut (.i_mclk(clk), .i_sys_rst(rst), .i_cmd_valid(cv), .o_cmd_ready(rdy), .i_cmd_op(op),
    .i_cmd_all(call), .i_cmd_id(id), .i_cmd_value(val), .o_tx_valid(txv), .o_tx_data(txd), .i_tx_ready(txr),
    .o_err_code(ert), .i_err_read(er), .i_axis_pos(pos), .i_travel_min(tmin), .i_axis_moving(mov),
    .i_on_target(ont), .i_servo_on(srv), .i_soft_limit_en(sle), .o_low_limit(lim), .o_low_limit_hit(hit),
    .i_ain_fitted(fit), .i_smp_valid(sv), .i_smp_chan(sc), .i_smp_data(sd), .o_ain_mean(mean),
    .o_ain_mean_valid(mv));
  avsl_host u_host (.i_mclk(clk), .i_slow(slow), .i_tx_valid(txv), .i_tx_data(txd), .o_tx_ready(txr));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic waitrdy;
    int n;
    n = 0;
    while (!rdy && n < 9000) begin
      @(negedge clk);
      n++;
    end
    if (!rdy) num_errors++;
  endtask
  // Command held from a falling edge until the rising edge that takes it
  task automatic cmd(input avsl_pkg::avsl_op_t o, input logic a, input logic [3:0] i, input logic [31:0] v);
    @(negedge clk);
    op = o;
    call = a;
    id = i;
    val = v;
    cv = 1'b1;
    waitrdy();
    @(negedge clk);
    cv = 1'b0;
  endtask
  task automatic rej(input avsl_pkg::avsl_op_t o, input logic [3:0] i, input logic [31:0] v, input logic [7:0] c);
    cmd(o, 1'b0, i, v);
    check(ert, c);
    er = 1'b1;
    @(negedge clk);
    er = 1'b0;
    check(ert, 8'h00);
  endtask
  task automatic qry(input avsl_pkg::avsl_op_t o, input logic a, input logic [3:0] i, input string s);
    u_host.rx.delete();
    cmd(o, a, i, 32'h0);
    waitrdy();
    check(u_host.rx.size(), s.len());
    foreach (u_host.rx[k]) check(u_host.rx[k], s[k]);
  endtask
  task automatic t_avg;
    qry(op_ga, 1'b0, 4'h1, "1=1\n");
    cmd(op_sa, 1'b0, 4'h2, 32'h0000_2710);
    qry(op_ga, 1'b1, 4'h0, "1=1\n2=10000\n");
    rej(op_sa, 4'h1, 32'h0000_2711, avsl_pkg::ERR_VALUE);
    rej(op_sa, 4'h1, 32'h0000_0000, avsl_pkg::ERR_VALUE);
    rej(op_sa, 4'h0, 32'h0000_0005, avsl_pkg::ERR_BAD_ID);
    rej(op_sa, 4'h3, 32'h0000_0005, avsl_pkg::ERR_BAD_ID);
    slow = 1'b1;
    qry(op_ga, 1'b0, 4'h2, "2=10000\n");
    slow = 1'b0;
    fit = 2'b00;
    qry(op_ga, 1'b1, 4'h0, "\n");
    fit = 2'b11;
  endtask
  task automatic t_mean;
    int n;
    n = 0;
    cmd(op_sa, 1'b0, 4'h1, 32'h0000_0004);
    for (int k = 0; k < 4; k++) begin
      repeat (40) @(negedge clk);
      sd = 16'h000a * 16'(k + 1) + 16'(k / 3);
      sv = 1'b1;
      @(negedge clk);
      sv = 1'b0;
    end
    while (!mv[0] && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (!mv[0]) num_errors++;
    check(mean[15:0], 16'h0019);
    // Second channel, one sample per mean
    cmd(op_sa, 1'b0, 4'h2, 32'h0000_0001);
    sc = 1'b1;
    sd = 16'h0123;
    sv = 1'b1;
    @(negedge clk);
    sv = 1'b0;
    repeat (40) @(negedge clk);
    check(mean[31:16], 16'h0123);
    sc = 1'b0;
  endtask
  task automatic t_lim;
    pos[0] = 32'hffff_fff6;
    pos[6] = 32'h0000_0064;
    qry(op_gl, 1'b0, 4'h0, "X=-22\n");
    rej(op_sl, 4'h0, 32'hffff_fffb, avsl_pkg::ERR_SOFTLIM);
    rej(op_sl, 4'h0, 32'hffff_fff6, avsl_pkg::ERR_SOFTLIM);
    pos[0] = 32'h0000_0064;
    rej(op_sl, 4'h0, 32'h0000_0005, avsl_pkg::ERR_SOFTLIM);
    cmd(op_sl, 1'b0, 4'h6, 32'h0000_0005);
    check(lim[6], 32'h0000_0005);
    mov[0] = 1'b1;
    rej(op_sl, 4'h0, 32'hffff_fff1, avsl_pkg::ERR_MOVING);
    // Host retries only after motion has ended
    mov[0] = 1'b0;
    cmd(op_sl, 1'b0, 4'h0, 32'hffff_fff1);
    check(lim[0], 32'hffff_fff1);
    rej(op_sl, 4'h8, 32'hffff_fff1, avsl_pkg::ERR_BAD_ID);
    qry(op_gl, 1'b0, 4'h6, "A=5\n");
    pos[0] = 32'hffff_ffec;
    repeat (3) @(negedge clk);
    check(hit[0], 1'b0);
    sle[0] = 1'b1;
    repeat (3) @(negedge clk);
    check(hit[0], 1'b1);
    srv[0] = 1'b0;
    repeat (3) @(negedge clk);
    check(hit[0], 1'b0);
  endtask
  task automatic t_ont;
    ont = 8'h05;
    qry(op_ot, 1'b0, 4'h2, "Z=1\n");
    qry(op_ot, 1'b0, 4'h1, "Y=0\n");
    qry(op_ot, 1'b1, 4'h0, "X=1\nY=0\nZ=1\nU=0\nV=0\nW=0\nA=0\nB=0\n");
    rej(op_ot, 4'h9, 32'h0, avsl_pkg::ERR_BAD_ID);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(lim[0], 32'hffff_ffea);
    t_avg();
    t_mean();
    t_lim();
    t_ont();
    conclude();
  end
  initial begin
    #400000;
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire

// [src/avsl_avg.sv]
// Per-channel block averager: sums N samples, then divides by N
`timescale 1ns/10ps
`default_nettype none
module avsl_avg (
  input  wire logic                        i_mclk,         // System clock
  input  wire logic                        i_sys_rst,      // Synchronous reset
  input  wire logic                        i_smp_valid,    // Sample strobe for this channel
  input  wire logic [avsl_pkg::SMPW-1:0]   i_smp_data,     // Raw unsigned sample
  input  wire logic [avsl_pkg::NAVW-1:0]   i_navg,         // Samples per mean
  output logic [avsl_pkg::SMPW-1:0]        o_mean,         // Last mean
  output logic                             o_mean_valid    // One-cycle new-mean pulse
);
  localparam int SW = avsl_pkg::SMPW + avsl_pkg::NAVW;

  logic [SW-1:0]              sum_q;
  logic [avsl_pkg::NAVW-1:0]  cnt_q;
  logic [avsl_pkg::SMPW-1:0]  mean_q;
  logic                       start_q;
  logic [SW-1:0]              num_q;
  logic                       div_busy;
  logic                       div_done;
  logic [SW-1:0]              div_quo;

  wire [SW-1:0]             sum_n  = sum_q + SW'(i_smp_data);
  wire [avsl_pkg::NAVW-1:0] cnt_n  = cnt_q + avsl_pkg::NAVW'(1);
  wire                      blk_end = i_smp_valid && (cnt_n >= i_navg);

  // A block that completes while the previous division runs is dropped
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sum_q   <= '0;
      cnt_q   <= '0;
      num_q   <= '0;
      start_q <= 1'b0;
    end else begin
      start_q <= blk_end && !div_busy;
      if (blk_end) begin
        num_q <= sum_n;
        sum_q <= '0;
        cnt_q <= '0;
      end else if (i_smp_valid) begin
        sum_q <= sum_n;
        cnt_q <= cnt_n;
      end
    end
  end

  avsl_div #(.W(SW)) u_div (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_start   (start_q),
    .i_num     (num_q),
    .i_den     (SW'(i_navg)),
    .o_busy    (div_busy),
    .o_done    (div_done),
    .o_quo     (div_quo),
    .o_rem     ()
  );

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      mean_q       <= '0;
      o_mean_valid <= 1'b0;
    end else begin
      o_mean_valid <= div_done;
      if (div_done) begin
        mean_q <= div_quo[avsl_pkg::SMPW-1:0];
      end
    end
  end

  assign o_mean = mean_q;
endmodule
`default_nettype wire

// [src/avsl_div.sv]
// Serial restoring unsigned divider, one quotient bit per clock
`timescale 1ns/10ps
`default_nettype none
module avsl_div #(
  parameter int W = 32
) (
  input  wire logic         i_mclk,    // System clock
  input  wire logic         i_sys_rst, // Synchronous reset
  input  wire logic         i_start,   // Start pulse, taken when idle
  input  wire logic [W-1:0] i_num,     // Dividend
  input  wire logic [W-1:0] i_den,     // Divisor
  output logic              o_busy,    // Division in progress
  output logic              o_done,    // One-cycle result pulse
  output logic [W-1:0]      o_quo,     // Quotient
  output logic [W-1:0]      o_rem      // Remainder
);
  localparam int CW = $clog2(W) + 1;

  logic [W-1:0]  rem_q;
  logic [W-1:0]  quo_q;
  logic [W-1:0]  den_q;
  logic [CW-1:0] cnt_q;
  logic          busy_q;
  logic          done_q;
  wire  [W:0]    trial = {rem_q, quo_q[W-1]};
  wire  [W:0]    diff  = trial - {1'b0, den_q};
  wire           ge    = trial >= {1'b0, den_q};

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rem_q  <= '0;
      quo_q  <= '0;
      den_q  <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (i_start && !busy_q) begin
        rem_q  <= '0;
        quo_q  <= i_num;
        den_q  <= i_den;
        cnt_q  <= CW'(W);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        rem_q <= ge ? diff[W-1:0] : trial[W-1:0];
        quo_q <= {quo_q[W-2:0], ge};
        cnt_q <= cnt_q - CW'(1);
        if (cnt_q == CW'(1)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_quo  = quo_q;
  assign o_rem  = rem_q;
endmodule
`default_nettype wire

// [src/avsl_pkg.sv]
// Shared constants and types for the averaging, low soft limit and on-target command block
package avsl_pkg;

  localparam int AXES      = 8;
  localparam int PLAT_AXES = 6;
  localparam int AIN_CNT   = 2;
  localparam int VW        = 32;
  localparam int SMPW      = 16;
  localparam int NAVW      = 14;
  localparam int DIGS      = 10;

  localparam logic [NAVW-1:0]   NAV_DEF = 14'h0001;
  localparam logic signed [31:0] NAV_MIN = 32'sh0000_0001;
  localparam logic signed [31:0] NAV_MAX = 32'sh0000_2710;
  localparam logic [31:0]        DEC_BASE = 32'h0000_000a;

  localparam logic [7:0] ERR_NONE    = 8'h00;
  localparam logic [7:0] ERR_MOVING  = 8'h05;
  localparam logic [7:0] ERR_BAD_ID  = 8'h0f;
  localparam logic [7:0] ERR_VALUE   = 8'h11;
  localparam logic [7:0] ERR_SOFTLIM = 8'h1b;

  localparam logic [7:0] CH_EQ    = 8'h3d;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_ONE   = 8'h31;
  // Axis names from index 7 down to 0: B A W V U Z Y X
  localparam logic [63:0] AXIS_CHARS = 64'h4241_5756_555a_5958;

  typedef enum logic [2:0] {
    OP_SET_AVERAGE_COUNT     = 3'h0,
    OP_GET_AVERAGE_COUNT     = 3'h1,
    OP_SET_LOW_SOFT_LIMIT    = 3'h2,
    OP_GET_LOW_SOFT_LIMIT    = 3'h3,
    OP_GET_ON_TARGET_STATE   = 3'h4
  } avsl_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_NEXT = 3'h1,
    ST_ID   = 3'h2,
    ST_EQ   = 3'h3,
    ST_DIV  = 3'h4,
    ST_SIGN = 3'h5,
    ST_DIG  = 3'h6,
    ST_LF   = 3'h7
  } avsl_st_t;

endpackage

// [src/avsl_top.sv]
// Command block: averaging count, low soft limit and on-target queries with text replies
`timescale 1ns/10ps
`default_nettype none
module avsl_top (
  input  wire logic                                     i_mclk,          // 100 MHz clock
  input  wire logic                                     i_sys_rst,       // Synchronous reset
  input  wire logic                                     i_cmd_valid,     // Parsed command present
  output logic                                          o_cmd_ready,     // Command taken
  input  wire avsl_pkg::avsl_op_t                       i_cmd_op,        // Command code
  input  wire logic                                     i_cmd_all,       // Query has no id
  input  wire logic [3:0]                               i_cmd_id,        // Axis 0-7 or channel 1-2
  input  wire logic signed [avsl_pkg::VW-1:0]           i_cmd_value,     // Set value
  output logic                                          o_tx_valid,      // Reply byte present
  output logic [7:0]                                    o_tx_data,       // Reply byte
  input  wire logic                                     i_tx_ready,      // Reply byte taken
  output logic [7:0]                                    o_err_code,      // Stored error code
  input  wire logic                                     i_err_read,      // Error query clears
  input  wire logic [avsl_pkg::AXES*avsl_pkg::VW-1:0]   i_axis_pos,      // Current positions
  input  wire logic [avsl_pkg::AXES*avsl_pkg::VW-1:0]   i_travel_min,    // Travel minima
  input  wire logic [avsl_pkg::AXES-1:0]                i_axis_moving,   // Axis in motion
  input  wire logic [avsl_pkg::AXES-1:0]                i_on_target,     // Axis on target
  input  wire logic [avsl_pkg::AXES-1:0]                i_servo_on,      // Closed loop active
  input  wire logic [avsl_pkg::AXES-1:0]                i_soft_limit_en, // Soft limits switched on
  output logic [avsl_pkg::AXES*avsl_pkg::VW-1:0]        o_low_limit,     // Low limits
  output logic [avsl_pkg::AXES-1:0]                     o_low_limit_hit, // Below enforced limit
  input  wire logic [avsl_pkg::AIN_CNT-1:0]             i_ain_fitted,    // Analog channel present
  input  wire logic                                     i_smp_valid,     // Analog sample strobe
  input  wire logic                                     i_smp_chan,      // Sample channel index
  input  wire logic [avsl_pkg::SMPW-1:0]                i_smp_data,      // Raw sample
  output logic [avsl_pkg::AIN_CNT*avsl_pkg::SMPW-1:0]   o_ain_mean,      // Averaged values
  output logic [avsl_pkg::AIN_CNT-1:0]                  o_ain_mean_valid // New mean pulse
);

  avsl_pkg::avsl_st_t         st_q;
  avsl_pkg::avsl_op_t         op_q;
  logic                       all_q;
  logic                       lone_q;
  logic                       init_q;
  logic [3:0]                 idx_q;
  logic                       neg_q;
  logic [3:0]                 ndig_q;
  logic [3:0]                 dig_q [avsl_pkg::DIGS];
  logic [31:0]                div_num_q;
  logic                       div_start_q;
  logic [7:0]                 err_q;
  logic [avsl_pkg::NAVW-1:0]  navg_q [avsl_pkg::AIN_CNT];
  logic signed [31:0]         lim_q [avsl_pkg::AXES];
  logic [avsl_pkg::AXES-1:0]  hit_q;
  logic                       div_done;
  logic [31:0]                div_quo;
  logic [31:0]                div_rem;

  // Command decode
  wire cmd_go     = i_cmd_valid && o_cmd_ready;
  wire op_set_nav = i_cmd_op == avsl_pkg::OP_SET_AVERAGE_COUNT;
  wire op_get_nav = i_cmd_op == avsl_pkg::OP_GET_AVERAGE_COUNT;
  wire op_set_nlm = i_cmd_op == avsl_pkg::OP_SET_LOW_SOFT_LIMIT;
  wire is_nav_cmd = op_set_nav || op_get_nav;
  wire is_set     = op_set_nav || op_set_nlm;
  wire is_query   = !is_set;
  wire id_checked = is_set || !i_cmd_all;

  wire [3:0] ain_idx    = i_cmd_id - 4'h1;
  wire       ain_id_ok  = (i_cmd_id != 4'h0) && (i_cmd_id <= 4'(avsl_pkg::AIN_CNT))
                          && i_ain_fitted[ain_idx[0]];
  wire       axis_id_ok = i_cmd_id < 4'(avsl_pkg::AXES);
  wire [2:0] cmd_axis   = i_cmd_id[2:0];

  wire nav_val_ok = (i_cmd_value >= avsl_pkg::NAV_MIN) && (i_cmd_value <= avsl_pkg::NAV_MAX);

  wire signed [31:0] cmd_pos = $signed(i_axis_pos[{cmd_axis, 5'h00} +: 32]);
  wire nlm_below   = i_cmd_value < cmd_pos;
  wire nlm_sign_ok = (i_cmd_id >= 4'(avsl_pkg::PLAT_AXES)) || i_cmd_value[31];
  wire nlm_still   = !i_axis_moving[cmd_axis];

  wire id_bad = id_checked && (is_nav_cmd ? !ain_id_ok : !axis_id_ok);

  wire [7:0] err_new =
    id_bad                                ? avsl_pkg::ERR_BAD_ID  :
    (op_set_nav && !nav_val_ok)           ? avsl_pkg::ERR_VALUE   :
    (op_set_nlm && !nlm_still)            ? avsl_pkg::ERR_MOVING  :
    (op_set_nlm && !nlm_below)            ? avsl_pkg::ERR_SOFTLIM :
    (op_set_nlm && !nlm_sign_ok)          ? avsl_pkg::ERR_SOFTLIM :
                                            avsl_pkg::ERR_NONE;

  wire cmd_rej = cmd_go && (err_new != avsl_pkg::ERR_NONE);
  wire cmd_ok  = cmd_go && (err_new == avsl_pkg::ERR_NONE);
  wire nav_wr  = cmd_ok && op_set_nav;
  wire nlm_wr  = cmd_ok && op_set_nlm;

  assign o_cmd_ready = (st_q == avsl_pkg::ST_IDLE) && !init_q;

  // Error store: a new rejection wins over a clear in the same cycle
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      err_q <= avsl_pkg::ERR_NONE;
    end else if (cmd_rej) begin
      err_q <= err_new;
    end else if (i_err_read) begin
      err_q <= avsl_pkg::ERR_NONE;
    end
  end

  assign o_err_code = err_q;

  // Averaging counts
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      for (int c = 0; c < avsl_pkg::AIN_CNT; c++) begin
        navg_q[c] <= avsl_pkg::NAV_DEF;
      end
    end else if (nav_wr) begin
      navg_q[ain_idx[0]] <= i_cmd_value[avsl_pkg::NAVW-1:0];
    end
  end

  // Low limits load the travel minima once after reset; only the set command moves them afterwards
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      init_q <= 1'b1;
      for (int a = 0; a < avsl_pkg::AXES; a++) begin
        lim_q[a] <= '0;
      end
    end else if (init_q) begin
      init_q <= 1'b0;
      for (int a = 0; a < avsl_pkg::AXES; a++) begin
        lim_q[a] <= $signed(i_travel_min[a*avsl_pkg::VW +: avsl_pkg::VW]);
      end
    end else if (nlm_wr) begin
      lim_q[cmd_axis] <= i_cmd_value;
    end
  end

  // Enforcement flags toward the motion logic
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      hit_q <= '0;
    end else begin
      for (int a = 0; a < avsl_pkg::AXES; a++) begin
        hit_q[a] <= i_soft_limit_en[a] && i_servo_on[a]
                    && ($signed(i_axis_pos[a*avsl_pkg::VW +: avsl_pkg::VW]) < lim_q[a]);
      end
    end
  end

  assign o_low_limit_hit = hit_q;

  for (genvar g = 0; g < avsl_pkg::AXES; g++) begin : g_lim
    assign o_low_limit[g*avsl_pkg::VW +: avsl_pkg::VW] = lim_q[g];
  end

  // Analog averaging per channel
  for (genvar c = 0; c < avsl_pkg::AIN_CNT; c++) begin : g_ain
    avsl_avg u_avg (
      .i_mclk       (i_mclk),
      .i_sys_rst    (i_sys_rst),
      .i_smp_valid  (i_smp_valid && (i_smp_chan == 1'(c))),
      .i_smp_data   (i_smp_data),
      .i_navg       (navg_q[c]),
      .o_mean       (o_ain_mean[c*avsl_pkg::SMPW +: avsl_pkg::SMPW]),
      .o_mean_valid (o_ain_mean_valid[c])
    );
  end

  // Reply item selection
  wire q_nav = op_q == avsl_pkg::OP_GET_AVERAGE_COUNT;
  wire q_nlm = op_q == avsl_pkg::OP_GET_LOW_SOFT_LIMIT;
  wire q_ont = op_q == avsl_pkg::OP_GET_ON_TARGET_STATE;

  wire [3:0]  n_items  = q_nav ? 4'(avsl_pkg::AIN_CNT) : 4'(avsl_pkg::AXES);
  wire        item_ok  = q_nav ? i_ain_fitted[idx_q[0]] : 1'b1;
  wire [31:0] item_val = q_nav ? 32'(navg_q[idx_q[0]]) :
                         q_ont ? {31'h0, i_on_target[idx_q[2:0]]} :
                                 lim_q[idx_q[2:0]];
  wire        item_neg = q_nlm && item_val[31];
  wire [31:0] item_mag = item_neg ? (32'h0 - item_val) : item_val;
  wire [7:0]  id_char  = q_nav ? (avsl_pkg::CH_ONE + {4'h0, idx_q}) :
                                 avsl_pkg::AXIS_CHARS[{idx_q[2:0], 3'h0} +: 8];
  wire [3:0]  dig_top  = ndig_q - 4'h1;

  assign o_tx_valid = (st_q == avsl_pkg::ST_ID) || (st_q == avsl_pkg::ST_EQ)
                      || (st_q == avsl_pkg::ST_SIGN) || (st_q == avsl_pkg::ST_DIG)
                      || (st_q == avsl_pkg::ST_LF);

  assign o_tx_data = (st_q == avsl_pkg::ST_ID)   ? id_char :
                     (st_q == avsl_pkg::ST_EQ)   ? avsl_pkg::CH_EQ :
                     (st_q == avsl_pkg::ST_SIGN) ? avsl_pkg::CH_MINUS :
                     (st_q == avsl_pkg::ST_DIG)  ? (avsl_pkg::CH_ZERO | {4'h0, dig_q[dig_top]}) :
                     (st_q == avsl_pkg::ST_LF)   ? avsl_pkg::CH_LF : 8'h00;

  wire tx_go = o_tx_valid && i_tx_ready;

  // Decimal conversion by repeated division by ten
  avsl_div #(.W(32)) u_dec (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_start   (div_start_q),
    .i_num     (div_num_q),
    .i_den     (avsl_pkg::DEC_BASE),
    .o_busy    (),
    .o_done    (div_done),
    .o_quo     (div_quo),
    .o_rem     (div_rem)
  );

  // Reply sequencer
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st_q        <= avsl_pkg::ST_IDLE;
      op_q        <= avsl_pkg::OP_SET_AVERAGE_COUNT;
      all_q       <= 1'b0;
      lone_q      <= 1'b0;
      idx_q       <= 4'h0;
      neg_q       <= 1'b0;
      ndig_q      <= 4'h0;
      div_num_q   <= 32'h0;
      div_start_q <= 1'b0;
    end else begin
      div_start_q <= 1'b0;
      case (st_q)
        avsl_pkg::ST_IDLE: begin
          if (cmd_ok && is_query) begin
            op_q   <= i_cmd_op;
            all_q  <= i_cmd_all;
            lone_q <= 1'b0;
            idx_q  <= i_cmd_all ? 4'h0 : (is_nav_cmd ? ain_idx : i_cmd_id);
            if (i_cmd_all && is_nav_cmd && !(|i_ain_fitted)) begin
              lone_q <= 1'b1;
              st_q   <= avsl_pkg::ST_LF;
            end else begin
              st_q <= i_cmd_all ? avsl_pkg::ST_NEXT : avsl_pkg::ST_ID;
            end
          end
        end
        avsl_pkg::ST_NEXT: begin
          if (idx_q >= n_items) begin
            st_q <= avsl_pkg::ST_IDLE;
          end else if (item_ok) begin
            st_q <= avsl_pkg::ST_ID;
          end else begin
            idx_q <= idx_q + 4'h1;
          end
        end
        avsl_pkg::ST_ID: begin
          if (tx_go) begin
            st_q <= avsl_pkg::ST_EQ;
          end
        end
        avsl_pkg::ST_EQ: begin
          if (tx_go) begin
            neg_q       <= item_neg;
            div_num_q   <= item_mag;
            div_start_q <= 1'b1;
            ndig_q      <= 4'h0;
            st_q        <= avsl_pkg::ST_DIV;
          end
        end
        avsl_pkg::ST_DIV: begin
          if (div_done) begin
            dig_q[ndig_q] <= div_rem[3:0];
            ndig_q        <= ndig_q + 4'h1;
            if (div_quo == 32'h0) begin
              st_q <= neg_q ? avsl_pkg::ST_SIGN : avsl_pkg::ST_DIG;
            end else begin
              div_num_q   <= div_quo;
              div_start_q <= 1'b1;
            end
          end
        end
        avsl_pkg::ST_SIGN: begin
          if (tx_go) begin
            st_q <= avsl_pkg::ST_DIG;
          end
        end
        avsl_pkg::ST_DIG: begin
          if (tx_go) begin
            ndig_q <= dig_top;
            if (ndig_q == 4'h1) begin
              st_q <= avsl_pkg::ST_LF;
            end
          end
        end
        avsl_pkg::ST_LF: begin
          if (tx_go) begin
            if (all_q && !lone_q) begin
              idx_q <= idx_q + 4'h1;
              st_q  <= avsl_pkg::ST_NEXT;
            end else begin
              st_q <= avsl_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          st_q <= avsl_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire
